// file: rtl/vrp_pkg.sv
/*
 * Package for the voice record/playback control block: timing constants,
 * state encoding and the output carrier struct.
 * Assumes a 10 MHz system clock; the sample rate comes from a divider.
 */
package vrp_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned SAMPLE_HZ_MAX   = 12_000;
   localparam int unsigned SAMPLE_HZ_MIN   = 4_000;
   localparam int unsigned SAMPLE_HZ_DEF   = 8_000;
   localparam int unsigned DEBOUNCE_US     = 20_000;
   localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
   localparam int unsigned BLINK_MS        = 125;
   localparam int unsigned BLINK_CYC       = (CLK_HZ / 1_000) * BLINK_MS;
   localparam int unsigned DIV_MAX_CYC     = CLK_HZ / SAMPLE_HZ_MIN;
   localparam int unsigned DIV_MIN_CYC     = CLK_HZ / SAMPLE_HZ_MAX;
   localparam int unsigned DIV_DEF_CYC     = CLK_HZ / SAMPLE_HZ_DEF;
   localparam int unsigned DIV_W           = 12;
   localparam logic [DIV_W-1:0] DIV_RST    = 12'h4e2;

   // ****************************************************************
   // States and carriers
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_REC  = 3'h2,
      ST_PLAY = 3'h4
   } vrp_state_t;

   typedef struct packed {
      logic spk_pos;
      logic spk_neg;
      logic spk_oe;
      logic line_oe;
      logic activity_indicator;
   } vrp_out_t;

   localparam logic [4:0] OUT_RST = 5'h01;

endpackage : vrp_pkg

// file: rtl/vrp_ctrl.sv
/*
 * Control logic of a single-message voice recorder: debounced buttons,
 * record/playback sequencing, sample address counter, end marker, outputs.
 * Assumes the analog cell array sits outside; this block gives it a write
 * strobe, an address and an end-marker write, and reads back the marker.
 */
// Function
// RULE_01: Recording begins when capture_button falls and stays low after debounce.
// RULE_02: Recording ends as soon as capture_button returns high.
// RULE_03: Debounced falling edge on edge_play_button starts playback.
// RULE_04: edge_play_button is debounced on both falling and rising edges.
// RULE_05: Debounced fall of level_play_button starts playback; play only while low.
// RULE_06: Playback stops as soon as level_play_button returns high.
// RULE_07: Speaker outputs are high impedance when idle or recording.
// RULE_08: line_current_out is driven only during playback.
// RULE_09: Indicator is low during record, blinks during playback.
// RULE_10: Sample rate set by rate divisor, limited to 4 to 12 kHz.
// RULE_11: One cell per sample, address advances once per sample period.
// RULE_12: Record has priority; it halts playback and starts at address zero.
// RULE_13: End marker written after last sample on release or full memory.
// RULE_14: Playback runs from address zero until the end marker, then idles.
// RULE_15: A second debounced edge_play_button fall ends edge playback.
`timescale 1ns/10ps
`default_nettype none

module vrp_ctrl #(
   parameter int unsigned ADDR_W       = 16,
   parameter int unsigned DEPTH        = 65536,
   parameter int unsigned DEBOUNCE_CYC = vrp_pkg::DEBOUNCE_CYC,
   parameter int unsigned BLINK_CYC    = vrp_pkg::BLINK_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic                     capture_button_n,
   input  wire logic                     edge_play_button_n,
   input  wire logic                     level_play_button_n,
   input  wire logic [vrp_pkg::DIV_W-1:0] rate_divisor,
   input  wire logic                     sample_in,
   input  wire logic                     end_marker_seen,
   output logic      [ADDR_W-1:0]        cell_addr,
   output logic                          cell_write,
   output logic                          end_marker_write,
   output logic                          speaker_pos_out,
   output logic                          speaker_neg_out,
   output logic                          speaker_oe,
   output logic                          line_current_out,
   output logic                          line_current_oe,
   output logic                          activity_indicator_n
);

   initial begin
      if (ADDR_W < 1 || ADDR_W > 24 || DEPTH > (1 << ADDR_W) || DEPTH < 2 ||
          DEBOUNCE_CYC < 1 || BLINK_CYC < 1)
         $error("vrp_ctrl: unsupported parameters");
   end

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   // Reset to the released level, so no false press follows reset

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
      end else begin
         sync1_reg <= {capture_button_n, edge_play_button_n, level_play_button_n};
         sync2_reg <= sync1_reg;
      end
   end

   wire logic cap_raw   = sync2_reg[2];
   wire logic edge_raw  = sync2_reg[1];
   wire logic level_raw = sync2_reg[0];

   // ****************************************************************
   // Debounce: falls need a stable low; only the edge button also
   // filters its rise, the others release at once
   // ****************************************************************
   localparam int unsigned DB_W = $clog2(DEBOUNCE_CYC + 1);
   logic [DB_W-1:0] db_cnt_reg [3];
   logic [2:0]      db_low_reg;
   logic [2:0]      db_raw;
   logic [2:0]      db_slow_rise;

   assign db_raw       = {cap_raw, edge_raw, level_raw};
   assign db_slow_rise = 3'h2; // [RULE_04]

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_db
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               db_cnt_reg[g] <= '0;
               db_low_reg[g] <= 1'b0;
            end else if (db_low_reg[g] == !db_raw[g]) begin
               db_cnt_reg[g] <= '0;
            end else if (db_raw[g] && !db_slow_rise[g]) begin
               db_low_reg[g] <= 1'b0;
               db_cnt_reg[g] <= '0;
            end else if (db_cnt_reg[g] == DB_W'(DEBOUNCE_CYC - 1)) begin
               db_low_reg[g] <= !db_raw[g]; // [RULE_01] [RULE_03] [RULE_05]
               db_cnt_reg[g] <= '0;
            end else begin
               db_cnt_reg[g] <= db_cnt_reg[g] + 1'b1;
            end
         end
      end
   endgenerate

   logic [2:0] db_low_d_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         db_low_d_reg <= 3'h0;
      else
         db_low_d_reg <= db_low_reg;
   end

   wire logic cap_fall   = db_low_reg[2] && !db_low_d_reg[2];
   wire logic cap_low    = db_low_reg[2];
   wire logic edge_fall  = db_low_reg[1] && !db_low_d_reg[1];
   wire logic level_fall = db_low_reg[0] && !db_low_d_reg[0];
   wire logic level_low  = db_low_reg[0];

   // ****************************************************************
   // Sample-rate divider, divisor clamped to the 4..12 kHz range
   // ****************************************************************
   logic [vrp_pkg::DIV_W-1:0] div_lim;
   logic [vrp_pkg::DIV_W-1:0] div_cnt_reg;
   logic                      sample_tick;

   always_comb begin
      div_lim = rate_divisor;
      if (rate_divisor < vrp_pkg::DIV_W'(vrp_pkg::DIV_MIN_CYC))
         div_lim = vrp_pkg::DIV_W'(vrp_pkg::DIV_MIN_CYC); // [RULE_10]
      else if (rate_divisor > vrp_pkg::DIV_W'(vrp_pkg::DIV_MAX_CYC))
         div_lim = vrp_pkg::DIV_W'(vrp_pkg::DIV_MAX_CYC); // [RULE_10]
   end

   assign sample_tick = (div_cnt_reg >= div_lim - 1'b1);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         div_cnt_reg <= '0;
      else if (sample_tick)
         div_cnt_reg <= '0;
      else
         div_cnt_reg <= div_cnt_reg + 1'b1;
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   vrp_pkg::vrp_state_t state_reg;
   vrp_pkg::vrp_state_t state_next;
   logic                edge_mode_reg;
   logic                edge_mode_next;
   logic                addr_clr;
   logic                rec_end;
   wire logic           mem_full = (cell_addr == ADDR_W'(DEPTH - 1));

   always_comb begin
      state_next     = state_reg;
      edge_mode_next = edge_mode_reg;
      addr_clr       = 1'b0;
      rec_end        = 1'b0;
      case (state_reg)
         vrp_pkg::ST_IDLE: begin
            if (cap_fall) begin
               state_next = vrp_pkg::ST_REC; // [RULE_01]
               addr_clr   = 1'b1;
            end else if (edge_fall || level_fall) begin
               state_next     = vrp_pkg::ST_PLAY; // [RULE_03] [RULE_05]
               edge_mode_next = edge_fall;
               addr_clr       = 1'b1;
            end
         end
         vrp_pkg::ST_REC: begin
            // Release acts on the synchronised level at once, no debounce
            if (!cap_raw) begin
               if (sample_tick && mem_full) begin
                  state_next = vrp_pkg::ST_IDLE; // [RULE_13]
                  rec_end    = 1'b1;
               end
            end else begin
               state_next = vrp_pkg::ST_IDLE; // [RULE_02]
               rec_end    = 1'b1;              // [RULE_13]
            end
         end
         vrp_pkg::ST_PLAY: begin
            if (cap_fall) begin
               state_next = vrp_pkg::ST_REC; // [RULE_12]
               addr_clr   = 1'b1;
            end else if (!edge_mode_reg && !level_low) begin
               state_next = vrp_pkg::ST_IDLE; // [RULE_06]
            end else if (edge_mode_reg && edge_fall) begin
               state_next = vrp_pkg::ST_IDLE; // [RULE_15]
            end else if (sample_tick && (end_marker_seen || mem_full)) begin
               state_next = vrp_pkg::ST_IDLE; // [RULE_14]
            end
         end
         default: state_next = vrp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= vrp_pkg::ST_IDLE;
         edge_mode_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         edge_mode_reg <= edge_mode_next;
      end
   end

   // ****************************************************************
   // Cell address and strobes
   // ****************************************************************
   // In record the address steps after the write strobe, so each sample
   // lands in its own cell and the end marker goes after the last one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         cell_addr <= '0;
      else if (addr_clr)
         cell_addr <= '0; // [RULE_12] [RULE_14]
      else if (cell_write && !mem_full)
         cell_addr <= cell_addr + 1'b1; // [RULE_11] [RULE_13]
      else if (sample_tick && state_reg == vrp_pkg::ST_PLAY && state_next == state_reg
               && !mem_full)
         cell_addr <= cell_addr + 1'b1; // [RULE_11] [RULE_14]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cell_write       <= 1'b0;
         end_marker_write <= 1'b0;
      end else begin
         cell_write       <= sample_tick && state_reg == vrp_pkg::ST_REC && !rec_end; // [RULE_11]
         end_marker_write <= rec_end; // [RULE_13]
      end
   end

   // ****************************************************************
   // Outputs: indicator and tri-state enables
   // ****************************************************************
   localparam int unsigned BL_W = $clog2(BLINK_CYC + 1);
   logic [BL_W-1:0] blink_cnt_reg;
   logic            blink_reg;
   vrp_pkg::vrp_out_t out_reg;
   // Blink phase restarts with every playback, so the first flash is full length

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (state_reg != vrp_pkg::ST_PLAY) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (blink_cnt_reg == BL_W'(BLINK_CYC - 1)) begin
         blink_cnt_reg <= '0;
         blink_reg     <= !blink_reg; // [RULE_09]
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_reg <= vrp_pkg::OUT_RST;
      end else begin
         out_reg.spk_oe  <= state_next == vrp_pkg::ST_PLAY; // [RULE_07]
         out_reg.line_oe <= state_next == vrp_pkg::ST_PLAY; // [RULE_08]
         out_reg.spk_pos <= (state_next == vrp_pkg::ST_PLAY) && sample_in;
         out_reg.spk_neg <= (state_next == vrp_pkg::ST_PLAY) && !sample_in;
         if (state_next == vrp_pkg::ST_REC)
            out_reg.activity_indicator <= 1'b0; // [RULE_09]
         else if (state_next == vrp_pkg::ST_PLAY)
            out_reg.activity_indicator <= blink_reg; // [RULE_09]
         else
            out_reg.activity_indicator <= 1'b1;
      end
   end

   // Line output carries the same sample as the speaker pair
   logic line_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         line_reg <= 1'b0;
      else
         line_reg <= (state_next == vrp_pkg::ST_PLAY) && sample_in; // [RULE_08]
   end

   assign speaker_pos_out      = out_reg.spk_pos;
   assign speaker_neg_out      = out_reg.spk_neg;
   assign speaker_oe           = out_reg.spk_oe;
   assign line_current_oe      = out_reg.line_oe;
   assign line_current_out     = line_reg;
   assign activity_indicator_n = out_reg.activity_indicator;

endmodule : vrp_ctrl

`default_nettype wire

// file: verif/vrp_ctrl_asserts.sv
/* Port checker for vrp_ctrl, bound to every instance.
   Assumes a 4-cycle debounce and an in-range rate_divisor. */
`timescale 1ns/10ps
`default_nettype none
module vrp_ctrl_asserts #(
   parameter int unsigned ADDR_W    = 16,
   parameter int unsigned BLINK_CYC = 8
) (
   input wire logic                        clk,
   input wire logic                        arst_n,
   input wire logic                        capture_button_n,
   input wire logic [vrp_pkg::DIV_W-1:0]   rate_divisor,
   input wire logic                        end_marker_seen,
   input wire logic [ADDR_W-1:0]           cell_addr,
   input wire logic                        cell_write,
   input wire logic                        end_marker_write,
   input wire logic                        speaker_oe,
   input wire logic                        line_current_oe,
   input wire logic                        activity_indicator_n
);
   logic [15:0] gap_reg;
   logic [23:0] blink_reg;
   logic [15:0] mark_cnt_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Gap is only judged between writes of one take, never across idle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) gap_reg <= 16'h0;
      else if (cell_write) gap_reg <= 16'h1;
      else if (activity_indicator_n && !speaker_oe) gap_reg <= 16'h0;
      else if (gap_reg != 16'h0) gap_reg <= gap_reg + 16'h1;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) blink_reg <= 24'h0;
      else if (!speaker_oe || $changed(activity_indicator_n)) blink_reg <= 24'h0;
      else blink_reg <= blink_reg + 24'h1;
   end
   // Cycles spent playing on the marker cell; one sample period at most
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) mark_cnt_reg <= 16'h0;
      else if (speaker_oe && end_marker_seen) mark_cnt_reg <= mark_cnt_reg + 16'h1;
      else mark_cnt_reg <= 16'h0;
   end
   sequence s_cap_held;
      $fell(capture_button_n) ##1 !capture_button_n [*8] ##1 !capture_button_n [*3];
   endsequence
   sequence s_rec_rel;
      !activity_indicator_n && !speaker_oe && $rose(capture_button_n);
   endsequence
   sequence s_cap_up;
      capture_button_n [*6];
   endsequence
   property p_spk_hiz;
      cell_write |-> !speaker_oe && !line_current_oe;
   endproperty
   a_spk_hiz: assert property (p_spk_hiz)
      else $error("output driven while recording");
   property p_oe_pair;
      line_current_oe == speaker_oe;
   endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("line and speaker enables differ");
   property p_led_rec;
      cell_write |-> !activity_indicator_n;
   endproperty
   a_led_rec: assert property (p_led_rec)
      else $error("indicator not low in record");
   property p_blink;
      speaker_oe |-> blink_reg <= BLINK_CYC;
   endproperty
   a_blink: assert property (p_blink)
      else $error("indicator stuck during playback");
   property p_rec_start;
      s_cap_held |-> !activity_indicator_n && !speaker_oe;
   endproperty
   a_rec_start: assert property (p_rec_start)
      else $error("held record press did not record");
   property p_rec_end;
      s_rec_rel |-> ##[1:6] end_marker_write;
   endproperty
   a_rec_end: assert property (p_rec_end)
      else $error("no end marker after release");
   property p_no_rec_idle;
      s_cap_up |-> !cell_write;
   endproperty
   a_no_rec_idle: assert property (p_no_rec_idle)
      else $error("write with record button up");
   property p_play_addr0;
      $rose(speaker_oe) |-> cell_addr == {ADDR_W{1'b0}};
   endproperty
   a_play_addr0: assert property (p_play_addr0)
      else $error("playback not from address zero");
   property p_marker_stop;
      speaker_oe && end_marker_seen |-> mark_cnt_reg <= 16'(rate_divisor);
   endproperty
   a_marker_stop: assert property (p_marker_stop)
      else $error("playback ran past end marker");
   property p_addr_step;
      $changed(cell_addr) && cell_addr != {ADDR_W{1'b0}} |->
         cell_addr == ADDR_W'($past(cell_addr) + 1'b1);
   endproperty
   a_addr_step: assert property (p_addr_step)
      else $error("address skipped a cell");
   property p_tick_gap;
      cell_write && gap_reg != 16'h0 |-> gap_reg == 16'(rate_divisor);
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("sample period differs from divisor");
endmodule : vrp_ctrl_asserts
bind vrp_ctrl vrp_ctrl_asserts #(.ADDR_W(ADDR_W), .BLINK_CYC(BLINK_CYC)) u_chk (
   .clk(clk), .arst_n(arst_n), .capture_button_n(capture_button_n),
   .rate_divisor(rate_divisor), .end_marker_seen(end_marker_seen), .cell_addr(cell_addr),
   .cell_write(cell_write), .end_marker_write(end_marker_write), .speaker_oe(speaker_oe),
   .line_current_oe(line_current_oe), .activity_indicator_n(activity_indicator_n));
`default_nettype wire

// file: verif/vrp_far_model.sv
/* Buttons with pull-ups and a one-marker cell array model.
   Assumes press_req is high while a button is pressed. */
`timescale 1ns/10ps
`default_nettype none
module vrp_far_model #(
   parameter int unsigned ADDR_W = 4
) (
   input  wire logic              clk,
   input  wire logic [2:0]        press_req,
   input  wire logic [ADDR_W-1:0] cell_addr,
   input  wire logic              cell_write,
   input  wire logic              end_marker_write,
   output logic                   capture_button_n,
   output logic                   edge_play_button_n,
   output logic                   level_play_button_n,
   output logic                   sample_in,
   output logic                   end_marker_seen
);
   logic [ADDR_W-1:0] mark_reg;
   logic              mark_ok_reg = 1'b0;
   initial {level_play_button_n, edge_play_button_n, capture_button_n} = 3'h7;
   always @(posedge clk) begin
      {level_play_button_n, edge_play_button_n, capture_button_n} <= ~press_req;
   end
   // A sample written over the marker cell erases the old marker
   always @(posedge clk) begin
      if (end_marker_write) begin
         mark_reg <= cell_addr;
         mark_ok_reg <= 1'b1;
      end else if (cell_write && cell_addr == mark_reg) mark_ok_reg <= 1'b0;
   end
   assign end_marker_seen = mark_ok_reg && cell_addr == mark_reg;
   assign sample_in = ^cell_addr;
endmodule : vrp_far_model
`default_nettype wire

// file: verif/vrp_ctrl_tb.sv
/* Self-checking bench for vrp_ctrl with button model.
   Assumes short debounce and blink counts and a 16-cell memory. */
`timescale 1ns/10ps
`default_nettype none
module vrp_ctrl_tb;
   logic                        clk = 1'b0;
   logic                        arst_n;
   logic [2:0]                  press_req;
   logic [vrp_pkg::DIV_W-1:0]   rate_divisor;
   logic                        cap_n, edge_n, lvl_n, sample_in, end_marker_seen;
   logic [3:0]                  cell_addr;
   logic                        cell_write, end_marker_write, spk_p, spk_n, line_out;
   logic                        speaker_oe, line_current_oe, activity_indicator_n;
   int                          n_errors = 0;
   int                          checks = 0;
   always #50 clk = ~clk;
   vrp_ctrl #(.ADDR_W(4), .DEPTH(16), .DEBOUNCE_CYC(4), .BLINK_CYC(8)) uut (
      .clk(clk), .arst_n(arst_n), .capture_button_n(cap_n), .edge_play_button_n(edge_n),
      .level_play_button_n(lvl_n), .rate_divisor(rate_divisor), .sample_in(sample_in),
      .end_marker_seen(end_marker_seen), .cell_addr(cell_addr), .cell_write(cell_write),
      .end_marker_write(end_marker_write), .speaker_pos_out(spk_p), .speaker_neg_out(spk_n),
      .speaker_oe(speaker_oe), .line_current_out(line_out), .line_current_oe(line_current_oe),
      .activity_indicator_n(activity_indicator_n));
   vrp_far_model #(.ADDR_W(4)) u_far (
      .clk(clk), .press_req(press_req), .cell_addr(cell_addr), .cell_write(cell_write),
      .end_marker_write(end_marker_write), .capture_button_n(cap_n),
      .edge_play_button_n(edge_n), .level_play_button_n(lvl_n), .sample_in(sample_in),
      .end_marker_seen(end_marker_seen));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic sig(input int s);
      case (s)
         0: return speaker_oe;
         1: return activity_indicator_n;
         2: return end_marker_write;
         default: return cell_write;
      endcase
   endfunction : sig
   task automatic wt(input int s, input logic v, input int lim);
      for (int k = 0; k < lim && sig(s) !== v; k++) @(negedge clk);
   endtask : wt
   task automatic hold(input int b, input logic v, input int n);
      press_req[b] = v;
      repeat (n) @(negedge clk);
   endtask : hold
   task automatic t_glitch;
      hold(0, 1'b1, 2);
      hold(0, 1'b0, 2);
      hold(1, 1'b1, 2);
      hold(1, 1'b0, 20);
      chk("glitch led", 1, activity_indicator_n);
      chk("glitch oe", 0, speaker_oe);
   endtask : t_glitch
   task automatic t_record;
      hold(0, 1'b1, 0);
      wt(1, 1'b0, 20);
      chk("rec led", 0, activity_indicator_n);
      chk("rec addr", 0, cell_addr);
      repeat (3) begin
         wt(3, 1'b1, 1000);
         chk("rec spk", 0, speaker_oe);
         @(negedge clk);
      end
      hold(0, 1'b0, 0);
      wt(2, 1'b1, 8);
      chk("rec marker", 1, end_marker_write);
      wt(1, 1'b1, 4);
      chk("rec end led", 1, activity_indicator_n);
   endtask : t_record
   task automatic t_edge;
      logic l;
      hold(1, 1'b1, 8);
      hold(1, 1'b0, 0);
      wt(0, 1'b1, 20);
      chk("edge oe", 1, speaker_oe);
      chk("edge line", 1, line_current_oe);
      chk("edge spk diff", 1, spk_p ^ spk_n);
      chk("edge line data", spk_p, line_out);
      repeat (100) @(negedge clk);
      l = activity_indicator_n;
      repeat (8) @(negedge clk);
      chk("blink", !l, activity_indicator_n);
      wt(0, 1'b0, 4000);
      chk("eom stop", 0, speaker_oe);
      hold(1, 1'b1, 8);
      hold(1, 1'b0, 30);
      chk("edge run", 1, speaker_oe);
      hold(1, 1'b1, 8);
      hold(1, 1'b0, 0);
      wt(0, 1'b0, 12);
      chk("edge stop", 0, speaker_oe);
      repeat (20) @(negedge clk);
   endtask : t_edge
   task automatic t_level;
      hold(2, 1'b1, 0);
      wt(0, 1'b1, 20);
      repeat (50) @(negedge clk);
      chk("lvl play", 1, speaker_oe);
      hold(2, 1'b0, 0);
      wt(0, 1'b0, 5);
      chk("lvl stop", 0, speaker_oe);
   endtask : t_level
   task automatic t_reset;
      hold(2, 1'b1, 0);
      wt(0, 1'b1, 20);
      arst_n = 1'b0;
      hold(2, 1'b0, 2);
      chk("rst oe", 0, speaker_oe);
      chk("rst line", 0, line_current_oe);
      chk("rst addr", 0, cell_addr);
      arst_n = 1'b1;
      repeat (20) @(negedge clk);
      chk("rst idle oe", 0, speaker_oe);
      chk("rst idle led", 1, activity_indicator_n);
   endtask : t_reset
   task automatic t_prio;
      hold(2, 1'b1, 0);
      wt(0, 1'b1, 20);
      hold(0, 1'b1, 0);
      wt(0, 1'b0, 12);
      chk("prio oe", 0, speaker_oe);
      chk("prio addr", 0, cell_addr);
      hold(2, 1'b0, 4);
      chk("prio led", 0, activity_indicator_n);
      hold(0, 1'b0, 0);
      wt(2, 1'b1, 8);
      @(negedge clk);
   endtask : t_prio
   task automatic t_full;
      hold(0, 1'b1, 0);
      wt(1, 1'b0, 20);
      wt(2, 1'b1, 14600);
      chk("full marker", 1, end_marker_write);
      wt(1, 1'b1, 4);
      chk("full led", 1, activity_indicator_n);
      hold(0, 1'b0, 4);
   endtask : t_full
   task automatic results;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      results();
   end
   initial begin
      arst_n = 1'b0;
      press_req = 3'h0;
      rate_divisor = 12'h384;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      t_glitch();
      t_record();
      t_edge();
      t_level();
      t_reset();
      t_prio();
      t_full();
      results();
   end
endmodule : vrp_ctrl_tb
`default_nettype wire
